/* common/compact_isa_defines.svh */
// Constants for the compact instruction execute block
// What this block does
// - Short return-address store: address is stack pointer plus immediate times four, zero-extended.
// - Extended return-address store: address is stack pointer plus sign-extended 16-bit immediate.
// - Both store forms write the whole 32-bit return link register word.
// - Misaligned store address raises address error and suppresses the write.
// - Exclusive-OR of two registers is written back into the first register.
// - Byte zero-extend keeps bits 7..0, clears the rest, writes back.
// - Halfword zero-extend keeps bits 15..0, clears the rest, writes back.
// - Extend prefix on a non-extensible instruction raises reserved instruction.
// - Compact branch target adds the offset to the following instruction's address.
// - Taken exception saves the instruction-set mode bit in the saved return PC.
// - PC-relative loads count as data references for watch and breakpoint matching.
// - Barrier jump-register forms behave like the plain jump-register forms.
`ifndef COMPACT_ISA_DEFINES_SVH
`define COMPACT_ISA_DEFINES_SVH
`define MAJ_EXTEND        5'h1E
`define MAJ_EIGHT_BIT_IMM 5'h0C
`define MAJ_TWO_REG       5'h1D
`define FN_STORE_LINK     3'h2
`define FN_XOR            5'h0E
`define FN_CONVERT        5'h11
`define FN_JUMP_REG       5'h00
`define CVT_ZERO_BYTE     3'h0
`define CVT_ZERO_HALF     3'h1
`define FLD_MAJOR_HI      4'hF
`define FLD_MAJOR_LO      4'hB
`define FLD_RX_HI         4'hA
`define FLD_RX_LO         4'h8
`define FLD_SUB_HI        4'h7
`define FLD_SUB_LO        4'h5
`define FLD_FUNC_HI       4'h4
`define FLD_FUNC_LO       4'h0
`define REG_STACK_PTR     5'h1D
`define REG_RETURN_LINK   5'h1F
`define BRANCH_LEN_SHORT  32'h0000_0002
`define BRANCH_LEN_EXT    32'h0000_0004
`define RST_WORD          32'h0000_0000
`endif

/* common/compact_isa_pkg.sv */
// Types shared by the compact instruction execute block
package compact_isa_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_EXEC  = 3'b010,
    ST_FAULT = 3'b100
  } exec_state_t;

  typedef enum logic [1:0] {
    EXC_NONE     = 2'h0,
    EXC_ADDR_ERR = 2'h1,
    EXC_RESV_INS = 2'h2
  } exc_code_t;

  // Instruction as handed over by the fetch/decode path
  typedef struct packed {
    logic        valid;
    logic        extended;      // Prefix halfword present
    logic [31:0] word;          // Prefix in 31:16, base in 15:0
    logic [31:0] pc;            // Address of first halfword
    logic        isa_mode;      // Compact mode bit
    logic        branch;        // Decoder says this is a branch
    logic [31:0] branch_off;    // Scaled, sign-extended offset
    logic        pc_rel_load;   // PC-relative load reference
    logic        jr_barrier;    // Barrier jump-register form
  } instr_t;

  // Register file read values
  typedef struct packed {
    logic [31:0] rx_val;
    logic [31:0] ry_val;
    logic [31:0] stk_ptr_val;
    logic [31:0] link_val;
  } reg_read_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
  } store_req_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  idx;
    logic [31:0] data;
  } reg_write_t;

  typedef struct packed {
    logic        valid;
    exc_code_t   code;
    logic [31:0] ret_pc;        // Bit 0 carries mode bit
    logic [31:0] bad_addr;
  } exc_t;
endpackage : compact_isa_pkg

/* rtl/compact_isa_store_extend_ops.sv */
// Execute stage for return-address stores, XOR and zero-extends
`timescale 1ns/10ps
`include "compact_isa_defines.svh"
module compact_isa_store_extend_ops
  import compact_isa_pkg::*;
(
  input  wire logic       core_clk,      // Core clock
  input  wire logic       sys_rst,       // Async reset, high
  input  wire instr_t     instr_in,      // Instruction from decode
  input  wire reg_read_t  regs_in,       // Register read values
  output logic            busy_ff,       // Unit executing
  output store_req_t      store_ff,      // Word store to memory
  output reg_write_t      wb_ff,         // Register write-back
  output exc_t            exc_ff,        // Exception report
  output logic [31:0]     branch_tgt_ff, // Compact branch target
  output logic            jump_reg_ff,   // Jump-register request
  output logic            data_ref_ff    // Data reference class
);

  exec_state_t state_ff;
  exec_state_t nxt_state;
  store_req_t  nxt_store;
  reg_write_t  nxt_wb;
  exc_t        nxt_exc;
  logic [31:0] nxt_branch_tgt;
  logic        nxt_jump_reg;
  logic        nxt_data_ref;
  logic        nxt_busy;

  // Decode fields
  logic [15:0] base_hw;
  logic [15:0] pfx_hw;
  logic [4:0]  major;
  logic [2:0]  rx_idx;
  logic [2:0]  sub3;
  logic [4:0]  func5;
  logic [15:0] ext_imm;
  logic [31:0] ea;
  logic        is_store_link;
  logic        is_xor;
  logic        is_zero_byte;
  logic        is_zero_half;
  logic        is_jr;

  // Fault and issue qualifiers
  logic        resv;
  logic        misalign;
  logic        fault;
  logic        accept;

  // Field extraction from prefix and base halfwords
  always_comb begin
    base_hw = instr_in.word[15:0];
    pfx_hw  = instr_in.word[31:16];
    major   = base_hw[`FLD_MAJOR_HI:`FLD_MAJOR_LO];
    rx_idx  = base_hw[`FLD_RX_HI:`FLD_RX_LO];
    sub3    = base_hw[`FLD_SUB_HI:`FLD_SUB_LO];
    func5   = base_hw[`FLD_FUNC_HI:`FLD_FUNC_LO];
    // Extended immediate is scattered across both halfwords
    ext_imm = {pfx_hw[4:0], pfx_hw[10:5], base_hw[4:0]};
  end

  // Instruction class decode
  always_comb begin
    is_store_link = (major == `MAJ_EIGHT_BIT_IMM) && (rx_idx == `FN_STORE_LINK);
    is_xor        = (major == `MAJ_TWO_REG) && (func5 == `FN_XOR);
    is_zero_byte  = (major == `MAJ_TWO_REG) && (func5 == `FN_CONVERT) && (sub3 == `CVT_ZERO_BYTE);
    is_zero_half  = (major == `MAJ_TWO_REG) && (func5 == `FN_CONVERT) && (sub3 == `CVT_ZERO_HALF);
    // Jump detection only looks at the major and function fields
    is_jr         = (major == `MAJ_TWO_REG) && (func5 == `FN_JUMP_REG);
  end

  // Effective address: short form scaled and zero-extended
  // Long form may reach below the stack pointer, so it is sign-extended
  always_comb begin
    if (instr_in.extended) begin
      ea = regs_in.stk_ptr_val + {{16{ext_imm[15]}}, ext_imm};
    end else begin
      ea = regs_in.stk_ptr_val + {22'h000000, base_hw[7:0], 2'h0};
    end
  end

  // Only the store and branch forms accept the prefix; for the store, bits 7:5 must be clear
  always_comb begin
    // Branches use the prefix to widen their offset
    resv     = instr_in.extended &&
               (!is_store_link || (sub3 != 3'h0)) && !instr_in.branch;
    misalign = is_store_link && (ea[1:0] != 2'h0);
    fault    = resv || misalign;
    accept   = instr_in.valid && !fault;
  end

  // Sequencer: one cycle per instruction
  always_comb begin
    nxt_state = ST_IDLE;
    nxt_busy  = 1'b0;
    if (instr_in.valid) begin
      nxt_busy  = 1'b1;
      // Fault state marks a cycle whose results were dropped
      nxt_state = fault ? ST_FAULT : ST_EXEC;
    end
  end

  // Sequencer registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      busy_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff  <= nxt_busy;
    end
  end

  // Word store of the return link value
  always_comb begin
    nxt_store = '0;
    // Any fault suppresses the write
    if (accept && is_store_link) begin
      nxt_store.valid = 1'b1;
      nxt_store.addr  = ea;
      nxt_store.data  = regs_in.link_val;
    end
  end

  // Store request register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      store_ff <= '0;
    end else begin
      store_ff <= nxt_store;
    end
  end

  // Register write-back for XOR and the zero-extends
  // Index is the 3-bit register field widened to five bits
  always_comb begin
    nxt_wb = '0;
    if (accept && is_xor) begin
      nxt_wb.valid = 1'b1;
      nxt_wb.idx   = {2'h0, rx_idx};
      nxt_wb.data  = regs_in.rx_val ^ regs_in.ry_val;
    end
    if (accept && is_zero_byte) begin
      nxt_wb.valid = 1'b1;
      nxt_wb.idx   = {2'h0, rx_idx};
      nxt_wb.data  = {24'h000000, regs_in.rx_val[7:0]};
    end
    if (accept && is_zero_half) begin
      nxt_wb.valid = 1'b1;
      nxt_wb.idx   = {2'h0, rx_idx};
      nxt_wb.data  = {16'h0000, regs_in.rx_val[15:0]};
    end
  end

  // Write-back register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ff <= '0;
    end else begin
      wb_ff <= nxt_wb;
    end
  end

  // Exception report; reserved outranks a misaligned address
  always_comb begin
    nxt_exc = '0;
    if (instr_in.valid && fault) begin
      nxt_exc.valid    = 1'b1;
      nxt_exc.code     = resv ? EXC_RESV_INS : EXC_ADDR_ERR;
      nxt_exc.ret_pc   = {instr_in.pc[31:1], instr_in.isa_mode};
      // Bad address only means something for the alignment fault
      nxt_exc.bad_addr = misalign ? ea : `RST_WORD;
    end
  end

  // Exception register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      exc_ff <= '0;
    end else begin
      exc_ff <= nxt_exc;
    end
  end

  // Target counts from the following instruction, so add this one's length
  always_comb begin
    nxt_branch_tgt = branch_tgt_ff;
    if (accept && instr_in.branch) begin
      nxt_branch_tgt = instr_in.pc + instr_in.branch_off +
                       (instr_in.extended ? `BRANCH_LEN_EXT : `BRANCH_LEN_SHORT);
    end
  end

  // Target register holds until the next branch
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      branch_tgt_ff <= `RST_WORD;
    end else begin
      branch_tgt_ff <= nxt_branch_tgt;
    end
  end

  // Jump request and reference class
  always_comb begin
    // Barrier form takes the same path as the plain jump
    nxt_jump_reg = accept && (is_jr || instr_in.jr_barrier);
    // Data class stands even on a faulting cycle
    nxt_data_ref = instr_in.valid && instr_in.pc_rel_load;
  end

  // Jump and class registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      jump_reg_ff <= 1'b0;
      data_ref_ff <= 1'b0;
    end else begin
      jump_reg_ff <= nxt_jump_reg;
      data_ref_ff <= nxt_data_ref;
    end
  end

endmodule : compact_isa_store_extend_ops

/* tb/mem_store_sink.sv */
// Memory-side model that accepts word stores
`timescale 1ns/10ps
module mem_store_sink
  import compact_isa_pkg::*;
(
  input  wire logic       core_clk,  // Clock
  input  wire logic       sys_rst,   // Reset
  input  wire store_req_t store_in,  // Store from core
  output logic [31:0]     last_addr, // Last written address
  output logic [31:0]     last_data  // Last written word
);
  // Take each store on the edge it stands
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst) {last_addr, last_data} <= '0;
    else if (store_in.valid) {last_addr, last_data} <= {store_in.addr, store_in.data};
endmodule : mem_store_sink

/* tb/compact_isa_store_extend_ops_asserts.sv */
// Port checker for the compact execute block
`timescale 1ns/10ps
`include "compact_isa_defines.svh"
module compact_isa_chk
  import compact_isa_pkg::*;
(
  input wire logic        core_clk,      // Clock
  input wire logic        sys_rst,       // Reset
  input wire instr_t      instr_in,      // Instruction
  input wire reg_read_t   regs_in,       // Reads
  input wire store_req_t  store_ff,      // Store
  input wire reg_write_t  wb_ff,         // Write-back
  input wire exc_t        exc_ff,        // Exception
  input wire logic [31:0] branch_tgt_ff, // Target
  input wire logic        jump_reg_ff,   // Jump
  input wire logic        data_ref_ff    // Data class
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Field decode, store address and branch target
  wire logic [31:0] w = instr_in.word;
  wire logic v = instr_in.valid;
  wire logic x = instr_in.extended;
  wire logic sra = v && w[15:8] == {`MAJ_EIGHT_BIT_IMM, `FN_STORE_LINK} && (!x || w[7:5] == 3'h0);
  wire logic two_reg = v && !x && w[15:11] == `MAJ_TWO_REG;
  wire logic [31:0] ea = regs_in.stk_ptr_val +
    (x ? {{16{w[20]}}, w[20:16], w[26:21], w[4:0]} : {22'h0, w[7:0], 2'h0});
  wire logic [31:0] bt = instr_in.pc + instr_in.branch_off + (x ? `BRANCH_LEN_EXT : `BRANCH_LEN_SHORT);
  AST_STORE: assert property (sra && ea[1:0] == 2'h0 |=> store_ff.valid && store_ff.addr == $past(ea)
    && store_ff.data == $past(regs_in.link_val)) else $error("store wrong");
  AST_ALIGN: assert property (sra && ea[1:0] != 2'h0 |=> exc_ff.valid && exc_ff.code == EXC_ADDR_ERR
    && !store_ff.valid) else $error("misaligned store taken");
  AST_XOR: assert property (two_reg && w[4:0] == `FN_XOR |=> wb_ff.valid
    && wb_ff.data == ($past(regs_in.rx_val) ^ $past(regs_in.ry_val))) else $error("xor wrong");
  AST_ZERO_BYTE: assert property (two_reg && w[7:0] == {`CVT_ZERO_BYTE, `FN_CONVERT} |=>
    wb_ff.data == {24'h0, $past(regs_in.rx_val[7:0])}) else $error("byte extend wrong");
  AST_ZERO_HALF: assert property (two_reg && w[7:0] == {`CVT_ZERO_HALF, `FN_CONVERT} |=>
    wb_ff.data == {16'h0, $past(regs_in.rx_val[15:0])}) else $error("half extend wrong");
  AST_RESV: assert property (v && x && !sra && !instr_in.branch |=> exc_ff.valid
    && exc_ff.code == EXC_RESV_INS && !wb_ff.valid) else $error("reserved not raised");
  AST_BRANCH: assert property (v && instr_in.branch |=> branch_tgt_ff == $past(bt)) else $error("target wrong");
  AST_MODE: assert property (exc_ff.valid |-> exc_ff.ret_pc[0] == $past(instr_in.isa_mode)) else $error("mode lost");
  AST_DREF: assert property (v && instr_in.pc_rel_load |=> data_ref_ff) else $error("not data class");
  AST_JRB: assert property (v && instr_in.jr_barrier |=> jump_reg_ff) else $error("barrier jump lost");
  // Main scenarios reached
  cover property (sra ##1 store_ff.valid);
  cover property (exc_ff.valid && exc_ff.code == EXC_ADDR_ERR);
  cover property (wb_ff.valid);
  cover property (exc_ff.valid && exc_ff.code == EXC_RESV_INS);
endmodule : compact_isa_chk
bind compact_isa_store_extend_ops compact_isa_chk chk (.core_clk, .sys_rst, .instr_in, .regs_in, .store_ff,
  .wb_ff, .exc_ff, .branch_tgt_ff, .jump_reg_ff, .data_ref_ff);

/* tb/test_compact_isa_store_extend_ops.sv */
// Bench for the compact execute block
`timescale 1ns/10ps
module test_compact_isa_store_extend_ops;
  import compact_isa_pkg::*;
  logic core_clk = 0, sys_rst = 1, bz, jr, dr;
  instr_t i = '0;
  reg_read_t r = '0;
  store_req_t st;
  reg_write_t wb;
  exc_t ex;
  logic [31:0] bt, m_a, m_d;
  int bad_count = 0, samples_checked = 0;
  always #50 core_clk = ~core_clk;
  compact_isa_store_extend_ops dut (.core_clk, .sys_rst, .instr_in(i), .regs_in(r), .busy_ff(bz), .store_ff(st),
    .wb_ff(wb), .exc_ff(ex), .branch_tgt_ff(bt), .jump_reg_ff(jr), .data_ref_ff(dr));
  mem_store_sink mem (.core_clk, .sys_rst, .store_in(st), .last_addr(m_a), .last_data(m_d));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // One instruction, outputs settled on return
  task automatic run(instr_t x, reg_read_t y);
    @(negedge core_clk);
    i = x;
    r = y;
    @(negedge core_clk);
    i.valid = 0;
  endtask : run
  function automatic instr_t mk(logic [31:0] w, logic e);
    mk = '0;
    mk.valid = 1;
    mk.extended = e;
    mk.word = w;
    mk.pc = 32'h400;
    mk.isa_mode = 1;
  endfunction : mk
  task automatic t_store;
    run(mk(32'h62FF, 0), '{0, 0, 32'h1000_0000, 32'hA5A5_5A5A});
    chk("st_addr", 32'h1000_03FC, st.addr);
    chk("busy", 1, bz);
    run(mk(32'hF7FF_621C, 1), '{0, 0, 32'h100, 32'h1234_5678});
    chk("st_data", 32'h1234_5678, st.data);
    @(negedge core_clk);
    chk("ext_addr", 32'hFC, m_a);
    chk("mem_data", 32'h1234_5678, m_d);
  endtask : t_store
  task automatic t_misalign;
    run(mk(32'h6201, 0), '{0, 0, 32'h102, 32'h1});
    chk("ae_code", EXC_ADDR_ERR, ex.code);
    chk("ae_store", 0, st.valid);
    chk("ae_addr", 32'h106, ex.bad_addr);
    run(mk(32'hF000_623C, 1), '{0, 0, 32'h100, 32'h1});
    chk("rsv_bits", EXC_RESV_INS, ex.code);
    chk("rsv_store", 0, st.valid);
  endtask : t_misalign
  task automatic t_regops;
    instr_t x;
    x = mk(32'hEBAE, 0);
    x.pc_rel_load = 1;
    run(x, '{32'hF0F0_1234, 32'h0FF0_1111, 0, 0});
    chk("xor", 32'hFF00_0325, wb.data);
    chk("xor_idx", 3, wb.idx);
    chk("dref", 1, dr);
    run(mk(32'hEA11, 0), '{32'h89AB_CDEF, 0, 0, 0});
    chk("zero_byte", 32'hEF, wb.data);
    run(mk(32'hEA31, 0), '{32'h89AB_CDEF, 0, 0, 0});
    chk("zero_half", 32'hCDEF, wb.data);
  endtask : t_regops
  task automatic t_resv_branch;
    instr_t x;
    run(mk(32'hF000_EBAE, 1), '{1, 2, 0, 0});
    chk("ri_code", EXC_RESV_INS, ex.code);
    chk("ri_wb", 0, wb.valid);
    chk("ret_pc", 32'h401, ex.ret_pc);
    x = mk(32'h1000, 0);
    x.branch = 1;
    x.branch_off = 32'h10;
    x.jr_barrier = 1;
    run(x, '0);
    chk("target", 32'h412, bt);
    chk("jr", 1, jr);
    run(mk(32'hE800, 0), '0);
    chk("plain_jr", 1, jr);
    chk("dref_off", 0, dr);
  endtask : t_resv_branch
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk) sys_rst = 0;
    t_store;
    t_misalign;
    t_regops;
    t_resv_branch;
    finish_test;
  end
  // Tests need some 30 cycles; cut off at 1000
  initial begin
    #100000;
    bad_count++;
    finish_test;
  end
endmodule : test_compact_isa_store_extend_ops
